/* File: interrupt_vector_status_map.svh */
// constants for the interrupt vector and system status block
`ifndef INTERRUPT_VECTOR_STATUS_MAP_SVH
`define INTERRUPT_VECTOR_STATUS_MAP_SVH
// register indices, byte address is four times the index
`define BREAK_STATUS_IDX   16'hFE00
`define RESET_SOURCE_IDX   16'hFE01
`define BREAK_FLAG_CTL_IDX 16'hFE03
`define PEND_LOW_IDX       16'hFE04
`define PEND_HIGH_IDX      16'hFE05
`define EV_STATUS_IDX      16'hFE10
`define EV_CLEAR_IDX       16'hFE11
`define EV_ENABLE_IDX      16'hFE12
`define TOP_PEND_IDX       16'hFE13
// field positions and reset values
`define WAIT_EXIT_BIT      1
`define CLEAR_EN_BIT       7
`define RESET_SOURCE_RST   8'h80
`define EV_WAIT            0
`define EV_CAUSE           1
`define EV_VECTOR          2
// vector table, high byte address of each pair
`define VEC_RESET          16'hFFFE
`define VEC_SWI            16'hFFFC
`define VEC_F1             16'hFFFA
`define VEC_F2             16'hFFF8
`define VEC_F3             16'hFFF6
`define VEC_F4             16'hFFF4
`define VEC_F5             16'hFFF2
`define VEC_F6             16'hFFF0
`define VEC_F7             16'hFFEE
`define VEC_F8             16'hFFEC
`define VEC_F9             16'hFFEA
`define VEC_F10            16'hFFE8
`define VEC_F11            16'hFFE6
`define VEC_F12            16'hFFE4
`define VEC_F13            16'hFFE2
`define VEC_F14            16'hFFE0
`define VEC_F15            16'hFFDE
`define VEC_F16            16'hFFDC
`define VEC_F17            16'hFFDA
`define VEC_F18            16'hFFD8
`define VEC_F19            16'hFFD6
`define VEC_F20            16'hFFD4
`define VEC_F21            16'hFFD2
`define VEC_RESERVED       16'hFFD0
`endif

/* File: interrupt_vector_status_pkg.sv */
// types shared by the interrupt vector and system status block
package interrupt_vector_status_pkg;

  // answer to a vector fetch
  typedef struct packed {
    logic        ack;
    logic [15:0] addr;
    logic [4:0]  flag;
  } vec_out_s;

  // cause report from the reset generator
  typedef struct packed {
    logic       strobe;
    logic [5:0] cause; // pad, watchdog, opcode, address, mode, low voltage
  } reset_cause_s;

  // whole state of the block
  typedef struct packed {
    logic [21:1] pend;
    logic        rst_pend;
    logic [7:0]  rst_src;
    logic        wait_flag;
    logic        clear_en;
    logic [2:0]  ev_sts;
    logic [2:0]  ev_en;
    logic        irq;
    logic        wr_act;
    logic [15:0] wr_idx;
    logic [31:0] hrdata;
    logic        hready;
    vec_out_s    vec;
  } state_s;

endpackage

/* File: interrupt_vector_status.sv */
// interrupt vector table, pending flags and system status registers
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "interrupt_vector_status_map.svh"
// Notes on behaviour
// - first timer overflow, flag 6, at FFF0
// - first timer channels 1, 0 at FFF2, FFF4
// - second timer overflow, flag 9, at FFEA
// - second timer channels 1, 0 at FFEC, FFEE
// - two-wire port, flag 10, at FFE8
// - serial port error/receive/transmit at FFE6-FFE2
// - converter complete, flag 15, at FFDE
// - spi receive FFDC, transmit FFDA
// - infrared port error/receive/transmit at FFD8-FFD4
// - low pending register: flags 6..1, bits 1:0 zero
// - high pending register: flags 14..7, read-only
// - reset source read-only, power-on after power-up
// - wait-exit flag bit 1, cleared by writing 0
// - break clear enable bit 7, resets 0
module interrupt_vector_status (
  input  wire logic                                ref_clk,
  input  wire logic                                reset_n,
  input  wire logic                                hsel,
  input  wire logic [31:0]                         haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic [2:0]                          hsize,
  input  wire logic [31:0]                         hwdata,
  input  wire logic                                hready,
  output logic      [31:0]                         hrdata,
  output logic                                     hreadyout,
  output logic                                     hresp,
  input  wire logic [21:1]                         irq_src,
  input  wire logic                                swi_req,
  input  wire logic                                vec_req,
  output interrupt_vector_status_pkg::vec_out_s    vec_out,
  input  wire interrupt_vector_status_pkg::reset_cause_s reset_cause,
  input  wire logic                                wait_exit_event,
  output logic                                     wait_exit_flag,
  output logic                                     break_flag_clear_enable,
  output logic                                     irq
);
  import interrupt_vector_status_pkg::*;

  state_s st_r;
  state_s st_nxt;

  // ****************************************
  // decoding helpers
  // ****************************************

  // vector pair of a numbered flag
  function automatic logic [15:0] vec_of(input logic [4:0] f);
    logic [15:0] a;
    a = `VEC_RESERVED;
    case (f)
      5'h01: a = `VEC_F1;
      5'h02: a = `VEC_F2;
      5'h03: a = `VEC_F3;
      5'h04: a = `VEC_F4;
      5'h05: a = `VEC_F5;
      5'h06: a = `VEC_F6;
      5'h07: a = `VEC_F7;
      5'h08: a = `VEC_F8;
      5'h09: a = `VEC_F9;
      5'h0A: a = `VEC_F10;
      5'h0B: a = `VEC_F11;
      5'h0C: a = `VEC_F12;
      5'h0D: a = `VEC_F13;
      5'h0E: a = `VEC_F14;
      5'h0F: a = `VEC_F15;
      5'h10: a = `VEC_F16;
      5'h11: a = `VEC_F17;
      5'h12: a = `VEC_F18;
      5'h13: a = `VEC_F19;
      5'h14: a = `VEC_F20;
      5'h15: a = `VEC_F21;
      default: a = `VEC_RESERVED;
    endcase
    return a;
  endfunction

  // winner among pending sources; lowest flag number has the highest pair
  // the order is fixed by the table itself: a higher pair always wins, so
  // no priority register exists and software cannot reorder the sources.
  // a pending reset beats software, and software beats every peripheral;
  // with nothing pending the reserved bottom pair is handed out as flag 0.
  // the scan is a plain priority chain of 21 stages; at this width it
  // fits a cycle easily, and a tree would only obscure the ordering.
  function automatic vec_out_s pick(input logic [21:1] p, input logic r,
                                    input logic s);
    vec_out_s v;
    v.ack  = 1'b1;
    v.flag = 5'h00;
    v.addr = `VEC_RESERVED;
    // scan upward from the bottom so the highest address is kept last
    for (int i = 21; i >= 1; i--) begin
      if (p[i]) begin
        v.flag = 5'(i);
        v.addr = vec_of(5'(i));
      end
    end
    if (s) begin
      v.flag = 5'h00;
      v.addr = `VEC_SWI;
    end
    if (r) begin
      v.flag = 5'h00;
      v.addr = `VEC_RESET;
    end
    return v;
  endfunction

  // register read multiplexer
  // reads of the pending registers show the sources as seen at the
  // address-phase edge; flags 15 to 21 have no register window at all and
  // are only visible through the top pending number or a vector fetch.
  // reserved bits and unmapped words read zero so software never sees
  // stale state through a hole in the map.
  function automatic logic [31:0] rd_mux(input state_s s, input logic [15:0] idx);
    logic [31:0] d;
    vec_out_s    t;
    d = 32'h0000_0000;
    t = pick(s.pend, s.rst_pend, 1'b0);
    case (idx)
      `BREAK_STATUS_IDX:   d[`WAIT_EXIT_BIT] = s.wait_flag;
      `RESET_SOURCE_IDX:   d[7:0] = {s.rst_src[7:1], 1'b0};
      `BREAK_FLAG_CTL_IDX: d[`CLEAR_EN_BIT] = s.clear_en;
      `PEND_LOW_IDX:       d[7:0] = {s.pend[6:1], 2'b00};
      `PEND_HIGH_IDX:      d[7:0] = s.pend[14:7];
      `EV_STATUS_IDX:      d[2:0] = s.ev_sts;
      `EV_ENABLE_IDX:      d[2:0] = s.ev_en;
      `TOP_PEND_IDX:       d[4:0] = t.flag;
      default:             d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // ****************************************
  // next state
  // ****************************************

  // data phase of a write first, so a following read sees it
  // hazard: a write and a hardware set may land in the same cycle; the
  // sets are applied after the write decode so the event is never lost.
  // the read multiplexer looks at the next state for the same reason,
  // which lets back-to-back write then read return the new value.
  always_comb begin
    logic take;
    take   = 1'b0;
    st_nxt = st_r;
    st_nxt.vec.ack = 1'b0;
    st_nxt.pend    = irq_src; // sources sampled every cycle
    st_nxt.hready  = 1'b1;    // zero wait states
    if (st_r.wr_act) begin
      case (st_r.wr_idx)
        `BREAK_STATUS_IDX: begin
          if (!hwdata[`WAIT_EXIT_BIT]) begin
            st_nxt.wait_flag = 1'b0;
          end
        end
        `BREAK_FLAG_CTL_IDX: st_nxt.clear_en = hwdata[`CLEAR_EN_BIT];
        `EV_CLEAR_IDX:       st_nxt.ev_sts = st_r.ev_sts & ~hwdata[2:0];
        `EV_ENABLE_IDX:      st_nxt.ev_en = hwdata[2:0];
        default:             st_nxt.ev_en = st_nxt.ev_en; // read-only or unmapped
      endcase
    end
    // events after clears: a set in the clearing cycle wins
    if (wait_exit_event) begin
      st_nxt.wait_flag        = 1'b1;
      st_nxt.ev_sts[`EV_WAIT] = 1'b1;
    end
    if (reset_cause.strobe) begin
      st_nxt.rst_src           = {1'b0, reset_cause.cause, 1'b0};
      st_nxt.ev_sts[`EV_CAUSE] = 1'b1;
    end
    // vector fetch answered on the next edge
    if (vec_req) begin
      st_nxt.vec      = pick(st_r.pend, st_r.rst_pend, swi_req);
      st_nxt.rst_pend = 1'b0;
      st_nxt.ev_sts[`EV_VECTOR] = 1'b1;
    end
    st_nxt.irq = |(st_r.ev_sts & st_r.ev_en);
    // address phase of the bus
    st_nxt.wr_act = 1'b0;
    st_nxt.hrdata = 32'h0000_0000;
    take = hsel && htrans[1] && hready;
    if (take && haddr[31:18] == 14'h0000 && haddr[1:0] == 2'b00) begin
      if (hwrite) begin
        st_nxt.wr_act = 1'b1;
        st_nxt.wr_idx = haddr[17:2];
      end else begin
        st_nxt.hrdata = rd_mux(st_nxt, haddr[17:2]);
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************

  // reset is power-on: only the power-on cause reads set
  // every reset branch value is a constant; a reset-vector fetch is left
  // pending so the first fetch after release always gets the top pair.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r          <= '0;
      st_r.rst_src  <= `RESET_SOURCE_RST;
      st_r.rst_pend <= 1'b1;
      st_r.hready   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign hrdata                  = st_r.hrdata;
  assign hreadyout               = st_r.hready;
  assign hresp                   = 1'b0 & st_r.hready;
  assign vec_out                 = st_r.vec;
  assign wait_exit_flag          = st_r.wait_flag;
  assign break_flag_clear_enable = st_r.clear_en;
  assign irq                     = st_r.irq;

  // ****************************************
  // assertions
  // ****************************************

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic rd_ok;
  assign rd_ok = hsel && htrans[1] && hready && !hwrite;

  a_vec_ack_next: assert property (vec_req |=> vec_out.ack ##1 !$past(vec_req) |-> !vec_out.ack)
    else $error("vector answer not one cycle after fetch");
  a_reset_first: assert property (vec_req && st_r.rst_pend |=> vec_out.addr == 16'hFFFE)
    else $error("reset vector not served first");
  a_first_timer_ovf: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[6:1] == 6'b100000 |=> vec_out.addr == 16'hFFF0 && vec_out.flag == 5'h06)
    else $error("first timer overflow vector wrong");
  a_second_timer_ovf: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[9:1] == 9'h100 |=> vec_out.addr == 16'hFFEA)
    else $error("second timer overflow vector wrong");
  a_two_wire_vec: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[10:1] == 10'h200 |=> vec_out.addr == 16'hFFE8)
    else $error("two-wire vector wrong");
  a_conv_done_vec: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[15:1] == 15'h4000 |=> vec_out.addr == 16'hFFDE)
    else $error("converter vector wrong");
  a_table_slope: assert property (vec_out.ack && vec_out.flag != 5'h00
      |-> vec_out.addr == 16'hFFFC - {10'h000, vec_out.flag, 1'b0})
    else $error("vector pair does not match flag");
  a_pend_low_read: assert property (rd_ok && haddr == {14'h0000, 16'hFE04, 2'b00}
      |=> hrdata[7:0] == {$past(irq_src[6:1]), 2'b00} && hrdata[31:8] == 24'h0)
    else $error("low pending read wrong");
  a_pend_high_read: assert property (rd_ok && haddr == {14'h0000, 16'hFE05, 2'b00}
      |=> hrdata[7:0] == $past(irq_src[14:7]))
    else $error("high pending read wrong");
  a_cause_capture: assert property (reset_cause.strobe
      |=> st_r.rst_src == {1'b0, $past(reset_cause.cause), 1'b0})
    else $error("reset source not recorded");
  a_wait_clear: assert property (st_r.wr_act && st_r.wr_idx == 16'hFE00 && !hwdata[1]
      && !wait_exit_event |=> !wait_exit_flag)
    else $error("wait-exit flag not cleared by zero");
  a_wait_set_wins: assert property (wait_exit_event |=> wait_exit_flag [*1])
    else $error("wait-exit event lost");
  a_clear_en_hold: assert property (!(st_r.wr_act && st_r.wr_idx == 16'hFE03)
      |=> $stable(break_flag_clear_enable))
    else $error("clear enable changed without write");
  a_irq_level: assert property (##1 irq == |($past(st_r.ev_sts) & $past(st_r.ev_en)))
    else $error("interrupt level mismatch");

  // each flag alone must land on its own pair, one cycle after the fetch
  for (genvar g = 1; g <= 21; g++) begin : g_flag_vec
    a_flag_alone: assert property (vec_req && !st_r.rst_pend && !swi_req
        && st_r.pend == (21'h000001 << (g - 1))
        |=> vec_out.flag == 5'(g) && vec_out.addr == 16'(32'hFFFC - 2 * g))
      else $error("single flag vector wrong");
  end

  // first timer channels
  a_t1_ch1_vec: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[5:1] == 5'h10 |=> vec_out.addr == 16'hFFF2)
    else $error("first timer channel 1 vector wrong");
  a_t1_ch0_vec: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[4:1] == 4'h8 |=> vec_out.addr == 16'hFFF4)
    else $error("first timer channel 0 vector wrong");

  // second timer channels
  a_t2_ch1_vec: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[8:1] == 8'h80 |=> vec_out.addr == 16'hFFEC)
    else $error("second timer channel 1 vector wrong");
  a_t2_ch0_vec: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[7:1] == 7'h40 |=> vec_out.addr == 16'hFFEE)
    else $error("second timer channel 0 vector wrong");

  // serial ports
  a_serial_err_vec: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[11:1] == 11'h400 |=> vec_out.addr == 16'hFFE6)
    else $error("serial error vector wrong");
  a_serial_tx_vec: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[13:1] == 13'h1000 |=> vec_out.addr == 16'hFFE2)
    else $error("serial transmit vector wrong");
  a_spi_rx_vec: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[16:1] == 16'h8000 |=> vec_out.addr == 16'hFFDC)
    else $error("spi receive vector wrong");
  a_spi_tx_vec: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[17:1] == 17'h10000 |=> vec_out.addr == 16'hFFDA)
    else $error("spi transmit vector wrong");
  a_ir_err_vec: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[18:1] == 18'h20000 |=> vec_out.addr == 16'hFFD8)
    else $error("infrared error vector wrong");
  a_ir_tx_vec: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend[20:1] == 20'h80000 |=> vec_out.addr == 16'hFFD4)
    else $error("infrared transmit vector wrong");

  // priority ends: software second, reserved pair when idle, reset once
  a_swi_second: assert property (vec_req && !st_r.rst_pend && swi_req
      |=> vec_out.addr == 16'hFFFC && vec_out.flag == 5'h00)
    else $error("software vector not second");
  a_none_bottom: assert property (vec_req && !st_r.rst_pend && !swi_req
      && st_r.pend == 21'h000000 |=> vec_out.addr == 16'hFFD0)
    else $error("idle fetch not at reserved pair");
  a_reset_once: assert property (vec_req |=> !st_r.rst_pend)
    else $error("reset vector still pending after fetch");
  a_vec_hold: assert property (!vec_req |=> $stable(vec_out.addr))
    else $error("vector address changed without fetch");

  // bus answer: never waits, always okay, data only in the data phase
  a_ready_always: assert property (hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (!hresp)
    else $error("error response given");
  a_rd_idle_zero: assert property (!rd_ok |=> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");

  // status register reads and writes
  a_src_read_bits: assert property (rd_ok && haddr == {14'h0000, 16'hFE01, 2'b00}
      |=> hrdata[0] == 1'b0 && hrdata[31:8] == 24'h000000)
    else $error("reset source read has stray bits");
  a_src_hold: assert property (!reset_cause.strobe |=> $stable(st_r.rst_src))
    else $error("reset source changed without strobe");
  a_break_read: assert property (rd_ok && haddr == {14'h0000, 16'hFE00, 2'b00}
      |=> hrdata[0] == 1'b0 && hrdata[31:2] == 30'h0)
    else $error("break status read has stray bits");
  a_wait_write_one: assert property (st_r.wr_act && st_r.wr_idx == 16'hFE00 && hwdata[1]
      |=> wait_exit_flag == ($past(wait_exit_flag) | $past(wait_exit_event)))
    else $error("writing one changed the wait-exit flag");
  a_ctl_read: assert property (rd_ok && haddr == {14'h0000, 16'hFE03, 2'b00}
      |=> hrdata[6:0] == 7'h00 && hrdata[31:8] == 24'h000000)
    else $error("break control read has stray bits");
  a_clear_en_write: assert property (st_r.wr_act && st_r.wr_idx == 16'hFE03
      |=> break_flag_clear_enable == $past(hwdata[7]))
    else $error("clear enable not written");
  a_ev_set_wins: assert property (st_r.wr_act && st_r.wr_idx == 16'hFE11
      && wait_exit_event |=> st_r.ev_sts[0])
    else $error("event lost against clear");

  c_bottom_fetch: cover property (vec_req && !st_r.rst_pend && !swi_req && st_r.pend == 21'h0);
  c_reset_fetch: cover property (vec_req && st_r.rst_pend);
  c_swi_fetch: cover property (vec_req && !st_r.rst_pend && swi_req);
  c_wait_clear: cover property (st_r.wr_act && st_r.wr_idx == 16'hFE00 && !hwdata[1]);
  c_irq_raised: cover property ($rose(irq));

endmodule // interrupt_vector_status

/* File: vector_fetch_core.sv */
// processor core model that fetches interrupt vectors from the block
`timescale 1ns/1ps
module vector_fetch_core (
  input  wire logic                                   ref_clk,
  output logic                                        vec_req,
  input  wire interrupt_vector_status_pkg::vec_out_s  vec_out
);
  import interrupt_vector_status_pkg::*;
  initial vec_req = 1'b0;
  // ****************************************************
  // fetch: one-cycle request, answer looked at one cycle later
  // ****************************************************
  task automatic fetch(output logic ack, output logic [15:0] addr, output logic [4:0] flag);
    @(posedge ref_clk);
    vec_req <= 1'b1;
    @(posedge ref_clk);
    vec_req <= 1'b0;
    // ack stands one cycle only, so it is caught mid-cycle
    @(negedge ref_clk);
    ack  = vec_out.ack;
    addr = vec_out.addr;
    flag = vec_out.flag;
  endtask
endmodule // vector_fetch_core

/* File: interrupt_vector_status_tb_top.sv */
// self-checking testbench of the interrupt vector and status block
`timescale 1ns/1ps
`include "interrupt_vector_status_map.svh"
module interrupt_vector_status_tb_top;
  import interrupt_vector_status_pkg::*;
  logic ref_clk, reset_n, hsel, hwrite, hreadyout, hresp, rdy_smp;
  logic [31:0] haddr, hwdata, hrdata, rd_smp, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [21:1] irq_src, pat;
  logic swi_req, vec_req, wait_exit_event, wait_exit_flag, break_flag_clear_enable, irq;
  logic ack;
  logic [15:0] va;
  logic [4:0] vf;
  vec_out_s vec_out;
  reset_cause_s reset_cause;
  int miscompares, checks;

  interrupt_vector_status uut (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq_src(irq_src), .swi_req(swi_req), .vec_req(vec_req), .vec_out(vec_out),
    .reset_cause(reset_cause), .wait_exit_event(wait_exit_event),
    .wait_exit_flag(wait_exit_flag), .break_flag_clear_enable(break_flag_clear_enable),
    .irq(irq));
  vector_fetch_core core (.ref_clk(ref_clk), .vec_req(vec_req), .vec_out(vec_out));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // mid-cycle copies keep the sample at the edge free of races
  always @(negedge ref_clk) begin
    rdy_smp <= hreadyout;
    rd_smp  <= hrdata;
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ****************************************************
  // single word transfer: address phase, then data phase
  // ****************************************************
  task automatic bus(logic w, logic [31:0] a, logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w; hsize <= 3'b010;
    do @(posedge ref_clk); while (rdy_smp !== 1'b1);
    htrans <= 2'b00; hwdata <= wd;
    do @(posedge ref_clk); while (rdy_smp !== 1'b1);
    rd = rd_smp;
  endtask
  function automatic logic [31:0] ba(logic [15:0] idx);
    return {14'h0, idx, 2'b00};
  endfunction
  task automatic wr(logic [15:0] idx, logic [31:0] d);
    bus(1'b1, ba(idx), d, rv);
  endtask
  task automatic rc(string nm, logic [15:0] idx, logic [31:0] exp);
    bus(1'b0, ba(idx), 32'h0, rv);
    chk(nm, rv, exp);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic look(int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic vchk(logic [15:0] ea, logic [4:0] ef);
    core.fetch(ack, va, vf);
    chk("ack", {31'h0, ack}, 32'h1);
    chk("vec addr", {16'h0, va}, {16'h0, ea});
    chk("vec flag", {27'h0, vf}, {27'h0, ef});
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #100us;
    miscompares++;
    report_and_stop;
  end

  // ****************************************************
  // test sequence
  // ****************************************************
  initial begin
    miscompares = 0; checks = 0; reset_n = 1'b0; hsel = 1'b0; haddr = 32'h0;
    htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; irq_src = '0;
    swi_req = 1'b0; wait_exit_event = 1'b0; reset_cause = '0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    // reset values, then the pending reset vector wins first
    rc("reset source", `RESET_SOURCE_IDX, 32'h80);
    rc("pend low", `PEND_LOW_IDX, 32'h0);
    rc("pend high", `PEND_HIGH_IDX, 32'h0);
    rc("break status", `BREAK_STATUS_IDX, 32'h0);
    rc("break ctl", `BREAK_FLAG_CTL_IDX, 32'h0);
    vchk(16'hFFFE, 5'd0);
    $display("test reset done");
    // every flag alone lands on its own pair
    for (int f = 1; f <= 21; f++) begin
      @(posedge ref_clk);
      irq_src <= 21'(1) << (f - 1);
      vchk(16'(16'hFFFC - 2 * f), 5'(f));
    end
    // several pending: higher address wins, software above every peripheral, none gives bottom
    irq_src <= 21'h1FFFFC;
    vchk(16'hFFF6, 5'd3);
    swi_req <= 1'b1;
    vchk(16'hFFFC, 5'd0);
    swi_req <= 1'b0; irq_src <= '0;
    vchk(16'hFFD0, 5'd0);
    $display("test vectors done");
    // pending registers mirror the flags and ignore writes
    pat = 21'h0B5A5B;
    irq_src <= pat;
    wr(`PEND_LOW_IDX, 32'hFF); wr(`PEND_HIGH_IDX, 32'h00);
    rc("pend low", `PEND_LOW_IDX, {24'h0, pat[6:1], 2'b00});
    rc("pend high", `PEND_HIGH_IDX, {24'h0, pat[14:7]});
    rc("top pending", `TOP_PEND_IDX, 32'h1);
    irq_src <= '0;
    // reset source loads on a strobe, read-only to software
    reset_cause <= '{strobe: 1'b1, cause: 6'b101011};
    @(posedge ref_clk);
    reset_cause <= '0;
    wr(`RESET_SOURCE_IDX, 32'hFF);
    rc("reset source", `RESET_SOURCE_IDX, 32'h56);
    rc("unmapped", 16'h0000, 32'h0);
    bus(1'b0, 32'h0004_0000, 32'h0, rv);
    chk("unmapped", rv, 32'h0);
    $display("test status done");
    // break control bit and its output
    wr(`BREAK_FLAG_CTL_IDX, 32'hFF);
    rc("break ctl", `BREAK_FLAG_CTL_IDX, 32'h80);
    chk("clear enable", {31'h0, break_flag_clear_enable}, 32'h1);
    // wait-exit flag: set, raise, mask and clear the interrupt
    rc("event status", `EV_STATUS_IDX, 32'h6);
    wr(`EV_CLEAR_IDX, 32'h7); wr(`EV_ENABLE_IDX, 32'h1);
    @(posedge ref_clk);
    wait_exit_event <= 1'b1;
    @(posedge ref_clk);
    wait_exit_event <= 1'b0;
    look(2);
    chk("irq", {31'h0, irq}, 32'h1);
    rc("event status", `EV_STATUS_IDX, 32'h1);
    wr(`BREAK_STATUS_IDX, 32'h2);
    rc("break status", `BREAK_STATUS_IDX, 32'h2);
    wr(`EV_ENABLE_IDX, 32'h0);
    look(2);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`EV_ENABLE_IDX, 32'h1);
    look(2);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    wr(`EV_CLEAR_IDX, 32'h1);
    look(2);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(`BREAK_STATUS_IDX, 32'h0);
    rc("break status", `BREAK_STATUS_IDX, 32'h0);
    chk("wait flag", {31'h0, wait_exit_flag}, 32'h0);
    $display("test break and interrupt done");
    report_and_stop;
  end
endmodule // interrupt_vector_status_tb_top
